// [core/lpm_pkg.sv]
// package: register map, field positions, keys and timing for the low-power controller
`default_nettype none
package lpm_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_PROTECT   = 8'h00;
  localparam logic [7:0] ADDR_STBY_CTL  = 8'h04;
  localparam logic [7:0] ADDR_DEEP_CTL  = 8'h08;
  localparam logic [7:0] ADDR_MSTOP_A   = 8'h0c;
  localparam logic [7:0] ADDR_MSTOP_B   = 8'h10;
  localparam logic [7:0] ADDR_MSTOP_C   = 8'h14;
  localparam logic [7:0] ADDR_WAKE_EN   = 8'h18;
  localparam logic [7:0] ADDR_WAKE_FLAG = 8'h1c;
  localparam logic [7:0] ADDR_PIN_SENSE = 8'h20;
  localparam logic [7:0] ADDR_FILT_EN   = 8'h24;
  localparam logic [7:0] ADDR_FILT_CLK  = 8'h28;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h2c;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h30;
  localparam logic [7:0] ADDR_MODE      = 8'h34;
  localparam logic [7:0] ADDR_WAIT_CMD  = 8'h38;
  // protect keys
  localparam logic [15:0] KEY_LOCK      = 16'ha500;
  localparam logic [15:0] KEY_MSTOP     = 16'ha502;
  localparam logic [15:0] KEY_STBY      = 16'ha503;
  // field positions
  localparam int unsigned SOFT_STANDBY_SELECT_BIT      = 15;
  localparam int unsigned HOLD_BIT      = 14;
  localparam int unsigned DEEP_BIT      = 7;
  localparam int unsigned ALL_MODULE_STOP_ENABLE_BIT      = 31;
  localparam int unsigned PIN8_BIT      = 0;
  localparam int unsigned SENSE_LSB     = 2;
  // required masks for all-module clock stop
  localparam logic [31:0] MSTOP_A_REQ   = 32'hffff_ffcf;
  localparam logic [31:0] MSTOP_B_REQ   = 32'hffff_ffff;
  localparam logic [15:0] MSTOP_C_REQ   = 16'hffff;
  // mask a bits that may stay clocked in clock stop
  localparam logic [31:0] MSTOP_A_DC    = 32'h0000_0030;
  localparam logic [1:0]  SENSE_FALL    = 2'h1;
  localparam logic [31:0] MSTOP_RESET   = 32'h4fff_ffff;
  // wake source count
  localparam int unsigned NUM_SRC       = 8;
  // deep wake internal reset time
  localparam int unsigned DEEP_RST_NS   = 800;
  localparam int unsigned CLK_NS        = 8;
  localparam int unsigned DEEP_RST_CYC  = (DEEP_RST_NS + CLK_NS - 1) / CLK_NS;
  // filter: three equal samples accepted
  localparam logic [1:0]  FILT_DIV32    = 2'h3;
  // interrupt status bits
  localparam int unsigned EV_SLEEP      = 0;
  localparam int unsigned EV_WAKE       = 1;
  localparam int unsigned EV_DEEP_WAKE  = 2;
  localparam int unsigned EV_PIN        = 3;
  localparam int unsigned NUM_EV        = 4;
  typedef enum logic [5:0] {
    ST_RUN   = 6'b000001,
    ST_SLEEP = 6'b000010,
    ST_ALLST = 6'b000100,
    ST_SSTBY = 6'b001000,
    ST_DEEP  = 6'b010000,
    ST_DRST  = 6'b100000
  } lpm_state_t;
  localparam logic [2:0] MODE_RUN   = 3'h0;
  localparam logic [2:0] MODE_SLEEP = 3'h1;
  localparam logic [2:0] MODE_ALLST = 3'h2;
  localparam logic [2:0] MODE_SSTBY = 3'h3;
  localparam logic [2:0] MODE_DEEP  = 3'h4;
  localparam logic [2:0] MODE_DRST  = 3'h5;
endpackage : lpm_pkg
`default_nettype wire

// [core/lpm_ctrl.sv]
// module: low-power mode controller with axi4-lite register slave
`default_nettype none
// What this block does
// - wait with standby and deep select both set enters deep standby
// - deep standby leaves only on enabled dedicated wake sources
// - deep wake holds internal reset fixed time, then releases and exits
// - after deep wake cpu resumes normal mode on low-speed oscillator
// - standby registers writable only after a503 key, a500 relocks
// - module stop masks writable only after a502 key, a500 relocks
// - wait with standby select clear never enters software standby
// - clock stop needs select 0, enable 1 and all-ones masks, except mask a bits 5:4 and mask c bits 15:0
// - all-module stop enable bit permits all-module clock stop
// - bus hold bit clear floats external bus in standby modes
// - standby 1 with deep 0 enters ordinary software standby
// - deep wake source cancels only when its enable bit is set
// - per-source cancel flag, cleared by writing zero
// - sense field 1 detects a falling edge on wake pin
// - per-pin noise filter, select 3 samples at pclk/32
// - filter used in normal mode only; wake ignores filter
// - unmasked timers run in clock stop, stopped ones hold outputs
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int unsigned RST_CYC = DEEP_RST_CYC
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // axi4-lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // cpu and interrupt sources
  input  wire logic                wait_exec,
  input  wire logic                any_irq,
  input  wire logic                stby_irq,
  input  wire logic [NUM_SRC-1:0]  deep_wake_src,
  input  wire logic                deep_wake_pin8,
  // outputs
  output logic                     pin8_irq,
  output logic                     cpu_halt,
  output logic                     periph_clk_stop,
  output logic                     osc_stop,
  output logic                     internal_rst,
  output logic                     low_speed_osc_sel,
  output logic                     bus_out_oe_n,
  output logic [31:0]              timer_run,
  output logic                     irq
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] src_s1, src_s2, next_src_s1, next_src_s2;
  logic               pin_s1, pin_s2, pin_s3;
  logic               next_pin_s1, next_pin_s2, next_pin_s3;

  always_comb begin
    next_src_s1 = deep_wake_src;
    next_src_s2 = src_s1;
    next_pin_s1 = deep_wake_pin8;
    next_pin_s2 = pin_s1;
    next_pin_s3 = pin_s2;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_s1 <= '0;
      src_s2 <= '0;
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
    end else begin
      src_s1 <= next_src_s1;
      src_s2 <= next_src_s2;
      pin_s1 <= next_pin_s1;
      pin_s2 <= next_pin_s2;
      pin_s3 <= next_pin_s3;
    end
  end

  // ---------------------------------------------------------------
  // registers and bus
  // ---------------------------------------------------------------
  logic [15:0]        protect, next_protect;
  logic [15:0]        stby_ctl, next_stby_ctl;
  logic [7:0]         deep_ctl, next_deep_ctl;
  logic [31:0]        mstop_a, mstop_b, mstop_c;
  logic [31:0]        next_mstop_a, next_mstop_b, next_mstop_c;
  logic [NUM_SRC-1:0] wake_en, next_wake_en, wake_flag, next_wake_flag;
  logic [7:0]         pin_sense, next_pin_sense;
  logic               filt_en, next_filt_en;
  logic [1:0]         filt_clk, next_filt_clk;
  logic [NUM_EV-1:0]  irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic               aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0]         aw_addr, next_aw_addr;
  logic [31:0]        w_data, next_w_data;
  logic               bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]         bresp, next_bresp, rresp, next_rresp;
  logic [31:0]        rdata, next_rdata;
  logic               wait_cmd, next_wait_cmd;
  logic [NUM_EV-1:0]  ev;
  logic               src_hit, do_wr;
  lpm_state_t         state, next_state;
  logic [2:0]         mode_code;

  // unlock state is the whole 16-bit protect value
  wire stby_ok  = protect == KEY_STBY;
  wire mstop_ok = protect == KEY_MSTOP;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
    end
    do_wr = aw_held && w_held && !bvalid;
    next_bvalid = bvalid;
    next_bresp  = bresp;
    if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    next_protect   = protect;
    next_stby_ctl  = stby_ctl;
    next_deep_ctl  = deep_ctl;
    next_mstop_a   = mstop_a;
    next_mstop_b   = mstop_b;
    next_mstop_c   = mstop_c;
    next_wake_en   = wake_en;
    next_pin_sense = pin_sense;
    next_filt_en   = filt_en;
    next_filt_clk  = filt_clk;
    next_irq_mask  = irq_mask;
    next_wait_cmd  = 1'b0;
    next_wake_flag = wake_flag;
    next_irq_stat  = irq_stat;
    if (do_wr) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = 2'b00;
      case (aw_addr)
        ADDR_PROTECT:   next_protect = w_data[15:0];
        ADDR_STBY_CTL:  if (stby_ok) next_stby_ctl = w_data[15:0];
        ADDR_DEEP_CTL:  if (stby_ok) next_deep_ctl = w_data[7:0];
        ADDR_MSTOP_A:   if (mstop_ok) next_mstop_a = w_data;
        ADDR_MSTOP_B:   if (mstop_ok) next_mstop_b = w_data;
        ADDR_MSTOP_C:   if (mstop_ok) next_mstop_c = w_data;
        ADDR_WAKE_EN:   if (stby_ok) next_wake_en = w_data[NUM_SRC-1:0];
        ADDR_WAKE_FLAG: next_wake_flag = wake_flag & w_data[NUM_SRC-1:0];
        ADDR_PIN_SENSE: next_pin_sense = w_data[7:0];
        ADDR_FILT_EN:   next_filt_en = w_data[PIN8_BIT];
        ADDR_FILT_CLK:  next_filt_clk = w_data[1:0];
        ADDR_IRQ_STAT:  next_irq_stat = irq_stat & ~w_data[NUM_EV-1:0];
        ADDR_IRQ_MASK:  next_irq_mask = w_data[NUM_EV-1:0];
        ADDR_WAIT_CMD:  next_wait_cmd = w_data[0];
        ADDR_MODE:      next_bresp = 2'b00;
        default:        next_bresp = 2'b10;
      endcase
    end
    // hardware sets win over software clears
    next_wake_flag = next_wake_flag | src_hit_vec(src_s2, wake_en, state);
    next_irq_stat  = next_irq_stat | ev;
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = 2'b00;
      case (s_axi_araddr)
        ADDR_PROTECT:   next_rdata = {16'h0, protect};
        ADDR_STBY_CTL:  next_rdata = {16'h0, stby_ctl};
        ADDR_DEEP_CTL:  next_rdata = {24'h0, deep_ctl};
        ADDR_MSTOP_A:   next_rdata = mstop_a;
        ADDR_MSTOP_B:   next_rdata = mstop_b;
        ADDR_MSTOP_C:   next_rdata = mstop_c;
        ADDR_WAKE_EN:   next_rdata = {{(32-NUM_SRC){1'b0}}, wake_en};
        ADDR_WAKE_FLAG: next_rdata = {{(32-NUM_SRC){1'b0}}, wake_flag};
        ADDR_PIN_SENSE: next_rdata = {24'h0, pin_sense};
        ADDR_FILT_EN:   next_rdata = {31'h0, filt_en};
        ADDR_FILT_CLK:  next_rdata = {30'h0, filt_clk};
        ADDR_IRQ_STAT:  next_rdata = {{(32-NUM_EV){1'b0}}, irq_stat};
        ADDR_IRQ_MASK:  next_rdata = {{(32-NUM_EV){1'b0}}, irq_mask};
        ADDR_MODE:      next_rdata = {29'h0, mode_code};
        ADDR_WAIT_CMD:  next_rdata = 32'h0;
        default: begin
          next_rdata = 32'h0;
          next_rresp = 2'b10;
        end
      endcase
    end
  end

  // enabled wake sources seen while in deep standby
  function automatic logic [NUM_SRC-1:0] src_hit_vec(
    input logic [NUM_SRC-1:0] s, input logic [NUM_SRC-1:0] en,
    input lpm_state_t st);
    src_hit_vec = (st == ST_DEEP) ? (s & en) : '0;
  endfunction : src_hit_vec

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      protect   <= KEY_LOCK;
      stby_ctl  <= 16'h4000;
      deep_ctl  <= 8'h00;
      mstop_a   <= MSTOP_RESET;
      mstop_b   <= 32'hffff_ffff;
      mstop_c   <= 32'hffff_0000;
      wake_en   <= '0;
      wake_flag <= '0;
      pin_sense <= 8'h00;
      filt_en   <= 1'b0;
      filt_clk  <= 2'h0;
      irq_stat  <= '0;
      irq_mask  <= '0;
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= 8'h00;
      w_data    <= 32'h0;
      bvalid    <= 1'b0;
      bresp     <= 2'b00;
      rvalid    <= 1'b0;
      rresp     <= 2'b00;
      rdata     <= 32'h0;
      wait_cmd  <= 1'b0;
    end else begin
      protect   <= next_protect;
      stby_ctl  <= next_stby_ctl;
      deep_ctl  <= next_deep_ctl;
      mstop_a   <= next_mstop_a;
      mstop_b   <= next_mstop_b;
      mstop_c   <= next_mstop_c;
      wake_en   <= next_wake_en;
      wake_flag <= next_wake_flag;
      pin_sense <= next_pin_sense;
      filt_en   <= next_filt_en;
      filt_clk  <= next_filt_clk;
      irq_stat  <= next_irq_stat;
      irq_mask  <= next_irq_mask;
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      aw_addr   <= next_aw_addr;
      w_data    <= next_w_data;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      rvalid    <= next_rvalid;
      rresp     <= next_rresp;
      rdata     <= next_rdata;
      wait_cmd  <= next_wait_cmd;
    end
  end

  // ---------------------------------------------------------------
  // wake pin: edge detect and noise filter
  // ---------------------------------------------------------------
  logic [4:0] div, next_div;
  logic [2:0] fshift, next_fshift;
  logic       fpin, next_fpin, pin_prev, next_pin_prev, next_pin8_irq;
  logic       samp, run_mode, pin_now;

  always_comb begin
    run_mode = state == ST_RUN;
    next_div = div + 5'h1;
    case (filt_clk)
      2'h0:       samp = 1'b1;
      2'h1:       samp = div[1:0] == 2'h0;
      2'h2:       samp = div[2:0] == 3'h0;
      FILT_DIV32: samp = div == 5'h0;
      default:    samp = 1'b1;
    endcase
    next_fshift = samp ? {fshift[1:0], pin_s3} : fshift;
    next_fpin = fpin;
    if (next_fshift == 3'b111)
      next_fpin = 1'b1;
    else if (next_fshift == 3'b000)
      next_fpin = 1'b0;
    // filter only while running; low-power paths use the raw pin
    pin_now = (filt_en && run_mode) ? fpin : pin_s3;
    next_pin_prev = pin_now;
    next_pin8_irq = 1'b0;
    case (pin_sense[SENSE_LSB+:2])
      SENSE_FALL: next_pin8_irq = pin_prev && !pin_now;
      2'h2:       next_pin8_irq = !pin_prev && pin_now;
      2'h3:       next_pin8_irq = pin_prev != pin_now;
      default:    next_pin8_irq = !pin_now;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div      <= 5'h0;
      fshift   <= 3'b111;
      fpin     <= 1'b1;
      pin_prev <= 1'b1;
      pin8_irq <= 1'b0;
    end else begin
      div      <= next_div;
      fshift   <= next_fshift;
      fpin     <= next_fpin;
      pin_prev <= next_pin_prev;
      pin8_irq <= next_pin8_irq;
    end
  end

  // ---------------------------------------------------------------
  // mode state machine
  // ---------------------------------------------------------------
  logic [15:0] rst_cnt, next_rst_cnt;
  logic        next_cpu_halt, next_pclk_stop, next_osc_stop, next_irst;
  logic        next_low_speed_osc, next_oe_n;
  logic [31:0] next_timer_run;
  logic        allst_ok, wait_go, next_irq;

  always_comb begin
    wait_go  = wait_exec || wait_cmd;
    allst_ok = mstop_a[ALL_MODULE_STOP_ENABLE_BIT]
               && (mstop_a | MSTOP_A_DC) == (MSTOP_A_REQ | MSTOP_A_DC)
               && mstop_b == MSTOP_B_REQ
               && mstop_c[31:16] == MSTOP_C_REQ;
    src_hit  = |(src_s2 & wake_en);
    next_state   = state;
    next_rst_cnt = rst_cnt;
    ev = '0;
    case (state)
      ST_RUN: if (wait_go) begin
        ev[EV_SLEEP] = 1'b1;
        if (!stby_ctl[SOFT_STANDBY_SELECT_BIT])
          next_state = allst_ok ? ST_ALLST : ST_SLEEP;
        else if (deep_ctl[DEEP_BIT])
          next_state = ST_DEEP;
        else
          next_state = ST_SSTBY;
      end
      ST_SLEEP, ST_ALLST: if (any_irq || next_pin8_irq) begin
        next_state = ST_RUN;
        ev[EV_WAKE] = 1'b1;
      end
      ST_SSTBY: if (stby_irq || next_pin8_irq) begin
        next_state = ST_RUN;
        ev[EV_WAKE] = 1'b1;
      end
      ST_DEEP: if (src_hit) begin
        next_state   = ST_DRST;
        next_rst_cnt = 16'(RST_CYC - 1);
      end
      ST_DRST: if (rst_cnt == 16'h0) begin
        next_state = ST_RUN;
        ev[EV_DEEP_WAKE] = 1'b1;
      end else begin
        next_rst_cnt = rst_cnt - 16'h1;
      end
      default: next_state = ST_RUN;
    endcase
    ev[EV_PIN] = next_pin8_irq;
    next_cpu_halt  = next_state != ST_RUN;
    next_pclk_stop = next_state inside {ST_ALLST, ST_SSTBY, ST_DEEP, ST_DRST};
    next_osc_stop  = next_state inside {ST_SSTBY, ST_DEEP, ST_DRST};
    next_irst      = next_state == ST_DRST;
    next_low_speed_osc      = low_speed_osc_sel;
    if (next_state == ST_DRST)
      next_low_speed_osc = 1'b1;
    next_oe_n = next_state inside {ST_ALLST, ST_SSTBY, ST_DEEP}
                && !stby_ctl[HOLD_BIT];
    // a timer runs in run, sleep and clock stop unless its mask bit stops it
    next_timer_run = (next_state == ST_RUN || next_state == ST_SLEEP)
                     ? ~mstop_a : (next_state == ST_ALLST ? ~mstop_a
                     : 32'h0);
    // a set mask bit silences its status bit
    next_irq = |(next_irq_stat & ~irq_mask);
    case (state)
      ST_RUN:   mode_code = MODE_RUN;
      ST_SLEEP: mode_code = MODE_SLEEP;
      ST_ALLST: mode_code = MODE_ALLST;
      ST_SSTBY: mode_code = MODE_SSTBY;
      ST_DEEP:  mode_code = MODE_DEEP;
      ST_DRST:  mode_code = MODE_DRST;
      default:  mode_code = MODE_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state             <= ST_RUN;
      rst_cnt           <= 16'h0;
      cpu_halt          <= 1'b0;
      periph_clk_stop   <= 1'b0;
      osc_stop          <= 1'b0;
      internal_rst      <= 1'b0;
      low_speed_osc_sel <= 1'b1;
      bus_out_oe_n      <= 1'b0;
      timer_run         <= 32'h0;
      irq               <= 1'b0;
    end else begin
      state             <= next_state;
      rst_cnt           <= next_rst_cnt;
      cpu_halt          <= next_cpu_halt;
      periph_clk_stop   <= next_pclk_stop;
      osc_stop          <= next_osc_stop;
      internal_rst      <= next_irst;
      low_speed_osc_sel <= next_low_speed_osc;
      bus_out_oe_n      <= next_oe_n;
      timer_run         <= next_timer_run;
      irq               <= next_irq;
    end
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

endmodule : lpm_ctrl
`default_nettype wire

// [bench/lpm_ctrl_asserts.sv]
// checker: port properties of the low-power controller
`default_nettype none
module lpm_chk #(
  parameter int unsigned RST_CYC = 100
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // cpu side
  input wire logic        wait_exec,
  input wire logic        any_irq,
  input wire logic        deep_wake_pin8,
  // outputs
  input wire logic        pin8_irq,
  input wire logic        cpu_halt,
  input wire logic        periph_clk_stop,
  input wire logic        osc_stop,
  input wire logic        internal_rst,
  input wire logic        low_speed_osc_sel,
  input wire logic        bus_out_oe_n,
  input wire logic [31:0] timer_run
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // --------
  // internal reset length counter
  // --------
  logic [15:0] rst_cnt;
  logic [15:0] next_rst_cnt;
  always_comb next_rst_cnt = internal_rst ? rst_cnt + 16'h1 : 16'h0;
  always_ff @(posedge clk) begin
    rst_cnt <= sys_rst ? 16'h0 : next_rst_cnt;
  end
  // --------
  // properties
  // --------
  osc_halt_a: assert property (osc_stop |-> cpu_halt && periph_clk_stop)
    else $error("standby with cpu or clocks running");
  bus_float_a: assert property (bus_out_oe_n |-> cpu_halt)
    else $error("bus floated in run mode");
  rst_len_a: assert property ($fell(internal_rst) |-> rst_cnt == 16'(RST_CYC))
    else $error("internal reset length wrong");
  deep_exit_a: assert property ($fell(internal_rst) |-> ##[0:2]
    (!cpu_halt && low_speed_osc_sel)) else $error("no run on slow osc");
  timer_hold_a: assert property (osc_stop |-> timer_run == 32'h0)
    else $error("timer running in standby");
  pin_edge_a: assert property ($rose(pin8_irq) |-> !deep_wake_pin8)
    else $error("pin request without low pin");
  wait_halt_a: assert property (wait_exec && !cpu_halt && !any_irq
    |-> ##[1:3] cpu_halt) else $error("wait did not halt cpu");
  irq_wake_a: assert property (cpu_halt && !osc_stop && !internal_rst
    && any_irq |-> ##[1:3] !cpu_halt) else $error("irq did not wake");
  cover property ($fell(internal_rst));
  cover property (bus_out_oe_n && !osc_stop);
  cover property (pin8_irq);
endmodule : lpm_chk
bind lpm_ctrl lpm_chk #(.RST_CYC(RST_CYC)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .wait_exec(wait_exec), .any_irq(any_irq),
  .deep_wake_pin8(deep_wake_pin8), .pin8_irq(pin8_irq),
  .cpu_halt(cpu_halt), .periph_clk_stop(periph_clk_stop),
  .osc_stop(osc_stop), .internal_rst(internal_rst),
  .low_speed_osc_sel(low_speed_osc_sel), .bus_out_oe_n(bus_out_oe_n),
  .timer_run(timer_run));
`default_nettype wire

// [bench/lpm_ctrl_tb.sv]
// testbench: directed scenarios for the low-power controller
`default_nettype none
module lpm_ctrl_tb
  import lpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, wait_exec;
  logic        any_irq, stby_irq, deep_wake_pin8, pin8_irq, cpu_halt;
  logic        periph_clk_stop, osc_stop, internal_rst, low_speed_osc_sel;
  logic        bus_out_oe_n, irq;
  logic [7:0]  awaddr, araddr, deep_wake_src;
  logic [31:0] wdata, rdata, timer_run;
  logic [1:0]  bresp, rresp;
  int          miscompares, samples_checked, cyc;
  lpm_ctrl #(.RST_CYC(4)) uut (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wait_exec(wait_exec),
    .any_irq(any_irq), .stby_irq(stby_irq), .deep_wake_src(deep_wake_src),
    .deep_wake_pin8(deep_wake_pin8), .pin8_irq(pin8_irq),
    .cpu_halt(cpu_halt), .periph_clk_stop(periph_clk_stop),
    .osc_stop(osc_stop), .internal_rst(internal_rst),
    .low_speed_osc_sel(low_speed_osc_sel), .bus_out_oe_n(bus_out_oe_n),
    .timer_run(timer_run), .irq(irq));
  always #4 clk = ~clk;
  // --------
  // shared tasks
  // --------
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = (rresp == 2'h2) ? 32'hdead_0002 : rdata;
    rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rdc
  task automatic mode_is(input logic [2:0] e);
    logic [31:0] d;
    for (int i = 0; i < 30; i++) begin
      rd(ADDR_MODE, d);
      if (d[2:0] === e) break;
    end
    chk(d, {29'h0, e});
  endtask : mode_is
  task automatic key(input logic [15:0] k);
    wr(ADDR_PROTECT, {16'h0, k});
  endtask : key
  task automatic do_wait();
    @(posedge clk);
    wait_exec <= 1'b1;
    @(posedge clk);
    wait_exec <= 1'b0;
  endtask : do_wait
  task automatic stby(input logic [31:0] c, input logic [31:0] dp);
    key(KEY_STBY);
    wr(ADDR_STBY_CTL, c);
    wr(ADDR_DEEP_CTL, dp);
    wr(ADDR_WAKE_EN, 32'h1);
    wr(ADDR_WAKE_FLAG, 32'h0);
    key(KEY_LOCK);
  endtask : stby
  // --------
  // scenarios
  // --------
  task automatic t_regs();
    rdc(ADDR_PROTECT, 32'h0000_a500);
    rdc(ADDR_STBY_CTL, 32'h0000_4000);
    rdc(ADDR_MSTOP_A, MSTOP_RESET);
    rdc(8'h3c, 32'hdead_0002);
    wr(ADDR_STBY_CTL, 32'h0000_8000);
    rdc(ADDR_STBY_CTL, 32'h0000_4000);
    key(KEY_MSTOP);
    wr(ADDR_STBY_CTL, 32'h0000_8000);
    rdc(ADDR_STBY_CTL, 32'h0000_4000);
    wr(ADDR_MSTOP_B, 32'h0000_1234);
    rdc(ADDR_MSTOP_B, 32'h0000_1234);
    key(KEY_LOCK);
    wr(ADDR_MSTOP_B, 32'hffff_ffff);
    rdc(ADDR_MSTOP_B, 32'h0000_1234);
  endtask : t_regs
  task automatic t_low();
    stby(32'h0, 32'h0);
    do_wait();
    mode_is(MODE_SLEEP);
    any_irq <= 1'b1;
    mode_is(MODE_RUN);
    any_irq <= 1'b0;
    key(KEY_MSTOP);
    wr(ADDR_MSTOP_A, 32'hffff_ffdf);
    wr(ADDR_MSTOP_B, 32'hffff_ffff);
    wr(ADDR_MSTOP_C, 32'hffff_0000);
    key(KEY_LOCK);
    do_wait();
    mode_is(MODE_ALLST);
    chk({31'h0, bus_out_oe_n}, 32'h1);
    chk(timer_run, 32'h0000_0020);
    any_irq <= 1'b1;
    mode_is(MODE_RUN);
    any_irq <= 1'b0;
    stby(32'h0000_8000, 32'h0);
    wr(ADDR_WAIT_CMD, 32'h1);
    mode_is(MODE_SSTBY);
    any_irq <= 1'b1;
    repeat (20) @(posedge clk);
    mode_is(MODE_SSTBY);
    any_irq <= 1'b0;
    stby_irq <= 1'b1;
    mode_is(MODE_RUN);
    stby_irq <= 1'b0;
  endtask : t_low
  task automatic t_deep();
    stby(32'h0000_8000, 32'h0000_0080);
    do_wait();
    mode_is(MODE_DEEP);
    deep_wake_src <= 8'h02;
    repeat (20) @(posedge clk);
    mode_is(MODE_DEEP);
    deep_wake_src <= 8'h01;
    mode_is(MODE_RUN);
    deep_wake_src <= 8'h00;
    chk({31'h0, low_speed_osc_sel}, 32'h1);
    rdc(ADDR_WAKE_FLAG, 32'h1);
    wr(ADDR_WAKE_FLAG, 32'h0);
    rdc(ADDR_WAKE_FLAG, 32'h0);
  endtask : t_deep
  task automatic t_pin();
    logic [31:0] d;
    int n;
    key(KEY_STBY);
    wr(ADDR_PIN_SENSE, {28'h0, SENSE_FALL, 2'h0});
    wr(ADDR_FILT_EN, 32'h1);
    wr(ADDR_FILT_CLK, {30'h0, FILT_DIV32});
    key(KEY_LOCK);
    wr(ADDR_IRQ_STAT, 32'hf);
    deep_wake_pin8 <= 1'b0;
    repeat (20) @(posedge clk);
    deep_wake_pin8 <= 1'b1;
    repeat (200) @(posedge clk);
    rd(ADDR_IRQ_STAT, d);
    chk(d & 32'h8, 32'h0);
    deep_wake_pin8 <= 1'b0;
    for (n = 0; n < 400 && pin8_irq !== 1'b1; n++) @(posedge clk);
    chk({31'h0, pin8_irq}, 32'h1);
    chk({31'h0, n >= 64}, 32'h1);
    deep_wake_pin8 <= 1'b1;
    rd(ADDR_IRQ_STAT, d);
    chk(d & 32'h8, 32'h8);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_MASK, 32'hf);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_STAT, 32'hf);
    wr(ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_pin
  initial begin
    {clk, awvalid, wvalid, bready, arvalid, rready, wait_exec} = 7'h0;
    {any_irq, stby_irq, awaddr, araddr, deep_wake_src} = 26'h0;
    {wdata, miscompares, samples_checked, cyc} = '0;
    sys_rst = 1'b1;
    deep_wake_pin8 = 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_low();
    t_deep();
    t_pin();
    print_verdict();
  end
endmodule : lpm_ctrl_tb
`default_nettype wire
